/* lsac_pkg.sv */
// Package for the LCD scan address and cursor block: command codes, register
// offsets, field positions and mode encodings shared by both ends.
// Assumes nothing of its surroundings beyond a SystemVerilog compiler.
package lsac_pkg;
    // Indirect command codes.
    localparam logic [7:0] CMD_PTR_WRITE = 8'h46;
    localparam logic [7:0] CMD_PTR_READ = 8'h47;
    localparam logic [7:0] CMD_DEPTH = 8'h60;
    localparam logic [7:0] CMD_STEP_DIR = 8'h4C;
    localparam logic [7:0] CMD_STEP_DIR_MASK = 8'hFC;
    localparam logic [7:0] CMD_SCAN_CFG = 8'h70;
    localparam logic [7:0] CMD_MEM_WRITE = 8'h42;
    localparam logic [7:0] CMD_MEM_READ = 8'h43;
    // Register offsets of the pointer bytes in the device.
    localparam logic [7:0] OFS_PTR_LOW = 8'h1C;
    localparam logic [7:0] OFS_PTR_HIGH = 8'h1D;
    // Depth field and its codes.
    localparam int DEPTH_W = 2;
    localparam logic [1:0] DEPTH_1BPP = 2'h0;
    localparam logic [1:0] DEPTH_2BPP = 2'h1;
    localparam logic [1:0] DEPTH_4BPP = 2'h2;
    // Cursor step directions.
    localparam logic [1:0] DIR_RIGHT = 2'h0;
    localparam logic [1:0] DIR_LEFT = 2'h1;
    localparam logic [1:0] DIR_UP = 2'h2;
    localparam logic [1:0] DIR_DOWN = 2'h3;
    // Scan configuration parameter byte count.
    localparam int SCAN_CFG_BYTES = 8;
    // Host register map over Avalon-MM (word addresses).
    localparam logic [2:0] HR_CMD = 3'h0;
    localparam logic [2:0] HR_DATA = 3'h1;
    localparam logic [2:0] HR_STATUS = 3'h2;
    localparam logic [2:0] HR_RDATA = 3'h3;
    localparam logic [31:0] HR_UNMAPPED = 32'hDEAD_BEEF;
endpackage

/* lsac_if.sv */
// Interface joining the host end and the device end: an 8-bit indirect bus with
// command and data locations, a strobe each way and a read-data return.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface lsac_if;
    logic cmd_sel;     // High: byte goes to command location, low: data location.
    logic wr_stb;      // One-cycle write strobe.
    logic rd_stb;      // One-cycle read strobe at the data location.
    logic [7:0] wdata; // Write byte, valid with wr_stb.
    logic [7:0] rdata; // Read byte, valid the cycle after rd_stb.
    logic rvalid;      // One-cycle pulse marking rdata.
    modport dev (input cmd_sel, wr_stb, rd_stb, wdata, output rdata, rvalid);
    modport host (output cmd_sel, wr_stb, rd_stb, wdata, input rdata, rvalid);
endinterface

/* lsac_dev.sv */
// Device end: command decoder, cursor pointer, scan address generator and
// line pulse for single or dual panels, text or graphics mode.
// Assumes a host on lsac_if and a display memory answering the scan address.
// Notes on behaviour
// - Pointer write: low byte, then high byte.
// - Pointer read returns low byte, then high.
// - Depth parameter: two low bits only.
// - Glyph origin top-left, bits horizontally adjacent.
// - Character field sized by size settings.
// - Widths up to sixteen use two bytes.
// - No gaps inserted; wide pitch needs two bytes.
// - Row scanned until characters-per-row, rows downward.
// - Graphics line start adds address pitch.
// - Text reuses start for each bitmap row.
// - Text fetches one byte per character.
// - Byte unpacks to eight, four, two pixels.
// - Dual panel fetches upper and lower alternately.
// - Idle total minus displayed cycles per line.
// - Dual panel: line pulse after lower screen.
// - One pointer for cursor and memory access.
// - Host saves and restores pointer off-screen.
// - Pointer steps by direction after access.
// - Cursor layer one or three by overlay.
// - Cursor hidden outside its layer region.
// - Dummy cursor needs graphics on, text off.
`timescale 1ns/1ps
module lsac_dev (
    input wire logic CLK_SYS,          // 40 MHz system clock.
    input wire logic NRST,             // Asynchronous reset, active low.
    lsac_if.dev BUS,                   // Indirect host bus.
    input wire logic [7:0] MEM_DATA,   // Display memory byte at SCAN_ADDR.
    input wire logic GFX_ON,           // Graphics screen displayed.
    input wire logic TEXT_ON,          // Text screen displayed.
    input wire logic OVERLAY_3,        // Three-layer overlay select.
    input wire logic [15:0] L1_BASE,   // Layer one region start.
    input wire logic [15:0] L1_END,    // Layer one region end, inclusive.
    input wire logic [15:0] L3_BASE,   // Layer three region start.
    input wire logic [15:0] L3_END,    // Layer three region end, inclusive.
    output logic [15:0] SCAN_ADDR,     // Display memory scan address.
    output logic SCAN_LOWER,           // High while the lower panel is fetched.
    output logic SCAN_ACTIVE,          // High during fetch cycles, low when idle.
    output logic [3:0] CG_ROW,         // Character generator row in text mode.
    output logic [7:0] PIXELS,         // Unpacked pixel byte, left pixel high.
    output logic [2:0] PIX_COUNT,      // Pixels per byte at current depth in graphics mode, eight in text mode.
    output logic LINE_PULSE,           // One-cycle end-of-line pulse.
    output logic [15:0] PTR,           // Cursor and memory access pointer.
    output logic [1:0] DEPTH,          // Bits-per-pixel selection.
    output logic CURSOR_VIS,           // Cursor shown in its layer.
    output logic CURSOR_LAYER3,        // Cursor drawn in layer three.
    output logic DUMMY_CURSOR,         // Dummy cursor over graphic characters.
    output logic MEM_WE,               // Memory write pulse, one cycle after the access, while PTR holds the stepped address.
    output logic [7:0] MEM_WDATA       // Memory write byte.
);
    import lsac_pkg::*;

    logic [7:0] cmd_q;
    logic [3:0] pidx_q;
    logic [15:0] ptr_q;
    logic [1:0] depth_q, dir_q;
    logic [7:0] cfg_q [SCAN_CFG_BYTES];
    logic [7:0] rdata_q;
    logic rvalid_q, mem_we_q;
    logic [7:0] mem_wdata_q;
    logic param_wr, param_rd, mem_acc;
    logic [15:0] step;

    // Config bytes: 0 chars/row, 1 total chars/row, 2-3 pitch, 4 rows,
    // 5 bitmap rows minus one, 6 bit0 graphics bit1 dual, 7 start high.
    logic [7:0] cr, tcr, lines, crow_last, mode;
    logic [15:0] pitch;
    assign cr = cfg_q[0];
    assign tcr = cfg_q[1];
    assign pitch = {cfg_q[3], cfg_q[2]};
    assign lines = cfg_q[4];
    assign crow_last = cfg_q[5];
    assign mode = cfg_q[6];

    assign param_wr = BUS.wr_stb & ~BUS.cmd_sel;
    assign param_rd = BUS.rd_stb;
    assign mem_acc = (param_wr & (cmd_q == CMD_MEM_WRITE))
                   | (param_rd & (cmd_q == CMD_MEM_READ));

    // Step per access; up and down move by one line pitch.
    always_comb begin
        unique case (dir_q)
            DIR_RIGHT: step = 16'h0001;
            DIR_LEFT: step = 16'hFFFF;
            DIR_UP: step = 16'h0000 - pitch;
            DIR_DOWN: step = pitch;
        endcase
    end

    // Command location latches the command and restarts parameter order.
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            cmd_q <= 8'h00;
            pidx_q <= 4'h0;
        end else if (BUS.wr_stb && BUS.cmd_sel) begin
            cmd_q <= BUS.wdata;
            pidx_q <= 4'h0;
        end else if ((param_wr || param_rd) && pidx_q != 4'hF) begin
            pidx_q <= pidx_q + 4'h1;
        end
    end

    // Pointer: loaded byte-wise or stepped after each memory access.
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            ptr_q <= 16'h0000;
        end else if (param_wr && cmd_q == CMD_PTR_WRITE && pidx_q == 4'h0) begin
            ptr_q[7:0] <= BUS.wdata;
        end else if (param_wr && cmd_q == CMD_PTR_WRITE && pidx_q == 4'h1) begin
            ptr_q[15:8] <= BUS.wdata;
        end else if (mem_acc) begin
            ptr_q <= ptr_q + step;
        end
    end

    // Depth, direction and scan configuration parameters.
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            depth_q <= DEPTH_1BPP;
            dir_q <= DIR_RIGHT;
            for (int i = 0; i < SCAN_CFG_BYTES; i++) begin
                cfg_q[i] <= 8'h00;
            end
        end else begin
            if (BUS.wr_stb && BUS.cmd_sel
                && (BUS.wdata & CMD_STEP_DIR_MASK) == CMD_STEP_DIR) begin
                dir_q <= BUS.wdata[1:0];
            end
            if (param_wr && cmd_q == CMD_DEPTH && pidx_q == 4'h0) begin
                depth_q <= BUS.wdata[DEPTH_W-1:0];
            end
            if (param_wr && cmd_q == CMD_SCAN_CFG && pidx_q < 4'(SCAN_CFG_BYTES)) begin
                cfg_q[pidx_q[2:0]] <= BUS.wdata;
            end
        end
    end

    // Read data: pointer bytes in order, or memory byte; memory writes.
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
            mem_we_q <= 1'b0;
            mem_wdata_q <= 8'h00;
        end else begin
            rvalid_q <= param_rd;
            mem_we_q <= param_wr && cmd_q == CMD_MEM_WRITE;
            if (param_wr) begin
                mem_wdata_q <= BUS.wdata;
            end
            if (param_rd) begin
                if (cmd_q == CMD_PTR_READ) begin
                    rdata_q <= (pidx_q == 4'h0) ? ptr_q[7:0] : ptr_q[15:8];
                end else begin
                    rdata_q <= MEM_DATA;
                end
            end
        end
    end
    assign BUS.rdata = rdata_q;
    assign BUS.rvalid = rvalid_q;

    // Raster scanner: column count, bitmap row, line, panel half.
    logic [7:0] col_q, line_q;
    logic [3:0] crow_q;
    logic lower_q, pulse_q;
    logic [15:0] lstart_q, addr_q;
    logic gfx, dual, line_end, last_half;
    assign gfx = mode[0];
    assign dual = mode[1];
    assign line_end = (col_q == tcr - 8'h01) || (tcr <= cr && col_q == cr - 8'h01);
    assign last_half = !dual || lower_q;

    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            col_q <= 8'h00;
            line_q <= 8'h00;
            crow_q <= 4'h0;
            lower_q <= 1'b0;
            lstart_q <= 16'h0000;
            addr_q <= 16'h0000;
            pulse_q <= 1'b0;
        end else begin
            pulse_q <= line_end && last_half;
            if (!line_end) begin
                col_q <= col_q + 8'h01;
                if (col_q < cr) begin
                    addr_q <= addr_q + 16'h0001;
                end
            end else begin
                col_q <= 8'h00;
                if (dual && !lower_q) begin
                    lower_q <= 1'b1;
                    addr_q <= lstart_q + {cfg_q[7], 8'h00};
                end else begin
                    lower_q <= 1'b0;
                    if (!gfx && crow_q != crow_last[3:0]) begin
                        crow_q <= crow_q + 4'h1;
                        addr_q <= lstart_q;
                    end else begin
                        crow_q <= 4'h0;
                        if (line_q + 8'h01 >= lines) begin
                            line_q <= 8'h00;
                            lstart_q <= 16'h0000;
                            addr_q <= 16'h0000;
                        end else begin
                            line_q <= line_q + 8'h01;
                            lstart_q <= lstart_q + pitch;
                            addr_q <= lstart_q + pitch;
                        end
                    end
                end
            end
        end
    end

    // Pixel unpacking by depth; glyph size and spacing come from the host's
    // bitmap layout, so the scanner inserts no gaps of its own.
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            PIXELS <= 8'h00;
            PIX_COUNT <= 3'h0;
        end else begin
            PIXELS <= MEM_DATA;
            unique case (gfx ? depth_q : DEPTH_1BPP)
                DEPTH_2BPP: PIX_COUNT <= 3'h4;
                DEPTH_4BPP: PIX_COUNT <= 3'h2;
                default: PIX_COUNT <= 3'h0; // Zero encodes eight pixels.
            endcase
        end
    end

    // Cursor layer, visibility and dummy cursor.
    logic in_l1, in_l3;
    assign in_l1 = ptr_q >= L1_BASE && ptr_q <= L1_END;
    assign in_l3 = ptr_q >= L3_BASE && ptr_q <= L3_END;
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            CURSOR_VIS <= 1'b0;
            CURSOR_LAYER3 <= 1'b0;
            DUMMY_CURSOR <= 1'b0;
        end else begin
            CURSOR_LAYER3 <= OVERLAY_3;
            CURSOR_VIS <= OVERLAY_3 ? in_l3 : in_l1;
            DUMMY_CURSOR <= GFX_ON && !TEXT_ON;
        end
    end

    assign SCAN_ADDR = addr_q;
    assign SCAN_LOWER = lower_q;
    assign SCAN_ACTIVE = col_q < cr;
    assign CG_ROW = crow_q;
    assign LINE_PULSE = pulse_q;
    assign PTR = ptr_q;
    assign DEPTH = depth_q;
    assign MEM_WE = mem_we_q;
    assign MEM_WDATA = mem_wdata_q;
endmodule

/* lsac_host.sv */
// Host end: an Avalon-MM slave whose registers issue command and data bytes
// on the indirect bus and capture the bytes read back.
// Assumes software that writes the command word before its parameters.
`timescale 1ns/1ps
module lsac_host (
    input wire logic CLK_SYS,            // 40 MHz system clock.
    input wire logic NRST,               // Asynchronous reset, active low.
    input wire logic [2:0] AVS_ADDRESS,  // Word address.
    input wire logic AVS_READ,           // Read request.
    input wire logic AVS_WRITE,          // Write request.
    input wire logic [31:0] AVS_WRITEDATA, // Write data.
    output logic [31:0] AVS_READDATA,    // Read data.
    output logic AVS_WAITREQUEST,        // Stall while a bus byte is in flight.
    lsac_if.host BUS                     // Indirect device bus.
);
    import lsac_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_DONE = 2'b10
    } lsac_st_e;

    lsac_st_e st_q;
    logic [7:0] rbyte_q;
    logic [7:0] count_q;
    logic cmd_sel_q, wr_q, rd_q;
    logic [7:0] wdata_q;
    logic [31:0] rd_q32;

    // Sequencer: writes finish in the same cycle as the strobe; a data-location
    // read holds waitrequest until the device returns its byte.
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            st_q <= ST_IDLE;
            cmd_sel_q <= 1'b0;
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            wdata_q <= 8'h00;
            rbyte_q <= 8'h00;
            count_q <= 8'h00;
        end else begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            unique case (st_q)
                ST_IDLE: begin
                    if (AVS_WRITE && (AVS_ADDRESS == HR_CMD || AVS_ADDRESS == HR_DATA)) begin
                        cmd_sel_q <= (AVS_ADDRESS == HR_CMD);
                        wdata_q <= AVS_WRITEDATA[7:0];
                        wr_q <= 1'b1;
                        count_q <= (AVS_ADDRESS == HR_CMD) ? 8'h00 : count_q + 8'h01;
                        st_q <= ST_DONE;
                    end else if (AVS_READ && AVS_ADDRESS == HR_DATA) begin
                        cmd_sel_q <= 1'b0;
                        rd_q <= 1'b1;
                        count_q <= count_q + 8'h01;
                        st_q <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (BUS.rvalid) begin
                        rbyte_q <= BUS.rdata;
                        st_q <= ST_DONE;
                    end
                end
                ST_DONE: st_q <= ST_IDLE;
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    assign BUS.cmd_sel = cmd_sel_q;
    assign BUS.wr_stb = wr_q;
    assign BUS.rd_stb = rd_q;
    assign BUS.wdata = wdata_q;

    // Register reads; unmapped words return a fixed marker.
    always_comb begin
        unique case (AVS_ADDRESS)
            HR_CMD: rd_q32 = {24'h00_0000, cmd_sel_q ? wdata_q : 8'h00};
            HR_DATA: rd_q32 = {24'h00_0000, (st_q == ST_WAIT) ? BUS.rdata : rbyte_q};
            HR_STATUS: rd_q32 = {23'h00_0000, st_q != ST_IDLE, count_q};
            HR_RDATA: rd_q32 = {24'h00_0000, rbyte_q};
            default: rd_q32 = HR_UNMAPPED;
        endcase
    end
    assign AVS_READDATA = rd_q32;

    // Writes to the command and data words and data reads stall until the sequencer
    // finishes; other accesses answer at once.
    assign AVS_WAITREQUEST = (AVS_WRITE || (AVS_READ && AVS_ADDRESS == HR_DATA))
                           && (AVS_ADDRESS == HR_CMD || AVS_ADDRESS == HR_DATA)
                           && st_q != ST_DONE;
endmodule

/* lsac_asserts.sv */
// Checker for the indirect bus between the host end and the device end.
// Assumes it sees the interface signals directly, on the one system clock.
`timescale 1ns/1ps
module lsac_asserts (
    input wire logic CLK_SYS, // System clock.
    input wire logic NRST, // Asynchronous reset, active low.
    input wire logic cmd_sel, // Command location select.
    input wire logic wr_stb, // Write strobe.
    input wire logic rd_stb, // Read strobe.
    input wire logic [7:0] wdata, // Write byte.
    input wire logic [7:0] rdata, // Read byte.
    input wire logic rvalid // Read byte marker.
);
    import lsac_pkg::*;
    logic [7:0] cmd_q;
    logic [3:0] wcnt_q;
    logic [3:0] rcnt_q;
    logic [15:0] ptr_q;
    logic fresh_q;

    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!NRST);

    // Last command and the count of data bytes written and read since it.
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            cmd_q <= 8'h00;
            wcnt_q <= 4'h0;
            rcnt_q <= 4'h0;
        end else if (wr_stb && cmd_sel) begin
            cmd_q <= wdata;
            wcnt_q <= 4'h0;
            rcnt_q <= 4'h0;
        end else begin
            wcnt_q <= wcnt_q + {3'h0, wr_stb};
            rcnt_q <= rcnt_q + {3'h0, rd_stb};
        end
    end

    // Shadow pointer; a memory access steps it, so the shadow is trusted no longer.
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            ptr_q <= 16'h0000;
            fresh_q <= 1'b1;
        end else if (wr_stb && cmd_sel && wdata[7:1] == CMD_MEM_WRITE[7:1]) begin
            fresh_q <= 1'b0;
        end else if (wr_stb && !cmd_sel && cmd_q == CMD_PTR_WRITE && wcnt_q < 4'h2) begin
            fresh_q <= 1'b1;
            if (wcnt_q == 4'h0) ptr_q[7:0] <= wdata;
            else ptr_q[15:8] <= wdata;
        end
    end

    AST_RD_ANSWER: assert property (rd_stb |=> rvalid)
        else $error("read strobe without read data next cycle");
    AST_RVALID_CAUSE: assert property (rvalid |-> $past(rd_stb))
        else $error("read data marker without a read strobe");
    AST_WR_PULSE: assert property (wr_stb |=> !wr_stb)
        else $error("write strobe longer than one cycle");
    AST_RD_PULSE: assert property (rd_stb |=> !rd_stb)
        else $error("read strobe longer than one cycle");
    AST_NO_BOTH: assert property (!(wr_stb && rd_stb))
        else $error("read and write strobes together");
    AST_PTR_LOW: assert property (rvalid && cmd_q == CMD_PTR_READ && rcnt_q == 4'h1 && fresh_q
        |-> rdata == ptr_q[7:0])
        else $error("first pointer byte read is not the low byte");
    AST_PTR_HIGH: assert property (rvalid && cmd_q == CMD_PTR_READ && rcnt_q == 4'h2 && fresh_q
        |-> rdata == ptr_q[15:8])
        else $error("second pointer byte read is not the high byte");
    AST_DEPTH_ZEROS: assert property (wr_stb && !cmd_sel && cmd_q == CMD_DEPTH && wcnt_q == 4'h0
        |-> wdata[7:2] == 6'h00)
        else $error("depth parameter upper bits not zero");
endmodule

/* lsac_tb.sv */
// Testbench joining the host end and the device end over the indirect bus.
// Assumes the Avalon master rules of the host end and a one-cycle display memory.
`timescale 1ns/1ps
module lsac_tb;
    import lsac_pkg::*;
    logic clk, nrst, av_rd, av_wr, gfx_on, text_on, overlay, ls_ok, scan_active, line_pulse;
    logic wrq, cur_vis, cur_l3, dummy, lower, mem_we;
    logic [3:0] cg_row;
    logic [2:0] av_addr, pix_count;
    logic [31:0] av_wd, rdd, q;
    logic [7:0] mem_data, pixels, mem_wdata;
    logic [15:0] scan_addr, ptr, ls;
    logic [1:0] depth;
    int fails, checks, len, act, lo;
    logic [15:0] st [4] = '{16'h0101, 16'h00FF, 16'h00F0, 16'h0110};
    logic [2:0] pc [3] = '{3'h0, 3'h4, 3'h2};

    lsac_if bus();
    lsac_host lsac_host_i(.CLK_SYS(clk), .NRST(nrst), .AVS_ADDRESS(av_addr), .AVS_READ(av_rd),
        .AVS_WRITE(av_wr), .AVS_WRITEDATA(av_wd), .AVS_READDATA(rdd), .AVS_WAITREQUEST(wrq),
        .BUS(bus));
    lsac_dev lsac_dev_i(.CLK_SYS(clk), .NRST(nrst), .BUS(bus), .MEM_DATA(mem_data),
        .GFX_ON(gfx_on), .TEXT_ON(text_on), .OVERLAY_3(overlay), .L1_BASE(16'h0000),
        .L1_END(16'h0FFF), .L3_BASE(16'h2000), .L3_END(16'h2FFF), .SCAN_ADDR(scan_addr),
        .SCAN_LOWER(lower), .SCAN_ACTIVE(scan_active), .CG_ROW(cg_row), .PIXELS(pixels),
        .PIX_COUNT(pix_count), .LINE_PULSE(line_pulse), .PTR(ptr), .DEPTH(depth),
        .CURSOR_VIS(cur_vis), .CURSOR_LAYER3(cur_l3), .DUMMY_CURSOR(dummy), .MEM_WE(mem_we),
        .MEM_WDATA(mem_wdata));
    lsac_asserts lsac_asserts_i(.CLK_SYS(clk), .NRST(nrst), .cmd_sel(bus.cmd_sel),
        .wr_stb(bus.wr_stb), .rd_stb(bus.rd_stb), .wdata(bus.wdata), .rdata(bus.rdata),
        .rvalid(bus.rvalid));

    // Display memory stand-in: one cycle latency, data tied to the address.
    always @(posedge clk) mem_data <= scan_addr[7:0] ^ 8'h3C;

    // Free-running system clock.
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic tally_and_finish();
        if (fails == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // One Avalon transfer; waitrequest and read data are taken at the rising edge itself,
    // before that edge's updates land, and the request is released at that same edge.
    task automatic av(input logic [2:0] a, input logic w, input logic [31:0] d);
        int n;
        @(posedge clk);
        av_addr <= a;
        av_wr <= w;
        av_rd <= !w;
        av_wd <= d;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (wrq === 1'b0) break;
        end
        if (n == 50) begin
            fails++;
            tally_and_finish();
        end
        q = rdd;
        av_wr <= 1'b0;
        av_rd <= 1'b0;
        @(negedge clk);
    endtask

    task automatic wb(input logic c, input logic [7:0] b);
        av(c ? HR_CMD : HR_DATA, 1'b1, {24'h0000_00, b});
    endtask

    task automatic setp(input logic [15:0] p);
        wb(1'b1, CMD_PTR_WRITE);
        wb(1'b0, p[7:0]);
        wb(1'b0, p[15:8]);
    endtask

    // Scan set-up: four characters of six, pitch 0x10, three lines, given mode.
    // Text mode gets two bitmap rows so that the repeated line start is exercised.
    task automatic cfg(input logic [7:0] mode);
        logic [7:0] v [8];
        v = '{8'h04, 8'h06, 8'h10, 8'h00, 8'h03, {7'h00, ~mode[0]}, mode, 8'h80};
        wb(1'b1, CMD_SCAN_CFG);
        for (int i = 0; i < 8; i++) wb(1'b0, v[i]);
    endtask

    // Measures one line from pulse to pulse, checking addresses and pixels on the way.
    task automatic line(input logic gfx);
        logic pa;
        logic [7:0] pm;
        logic [15:0] paddr, us;
        len = 0;
        act = 0;
        lo = 0;
        for (int n = 0; n < 300 && line_pulse !== 1'b1; n++) @(negedge clk);
        if (line_pulse !== 1'b1) begin
            fails++;
            tally_and_finish();
        end
        // The sample showing the pulse is the first fetch of the line, so it counts as seen.
        us = scan_addr;
        pa = (scan_active === 1'b1);
        do begin
            pm = mem_data;
            paddr = scan_addr;
            @(negedge clk);
            len++;
            if (lower === 1'b1) lo++;
            if (scan_active === 1'b1) begin
                act++;
                if (!pa && !gfx && lower === 1'b0 && cg_row === 4'h1) chk(scan_addr, us);
                if (pa) chk(scan_addr, paddr + 16'h0001);
                if (pa) chk(pixels, pm);
                if (!pa && gfx && ls_ok && scan_addr !== 16'h0000) chk(scan_addr, ls + 16'h0010);
                if (!pa) ls = scan_addr;
                if (!pa) ls_ok = 1'b1;
            end
            pa = (scan_active === 1'b1);
        end while (line_pulse !== 1'b1 && len < 300);
    endtask

    // Main sequence.
    initial begin
        {nrst, av_rd, av_wr, av_addr, av_wd, overlay, text_on, ls_ok} = '0;
        gfx_on = 1'b1;
        ls = 16'h0000;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        @(negedge clk);
        chk(ptr, 16'h0000);
        setp(16'h12A5);
        chk(ptr, 16'h12A5);
        av(HR_STATUS, 1'b0, 32'h0);
        chk(q[8:0], 9'h002);
        wb(1'b1, CMD_PTR_READ);
        av(HR_DATA, 1'b0, 32'h0);
        chk(q[7:0], 8'hA5);
        av(HR_DATA, 1'b0, 32'h0);
        chk(q[7:0], 8'h12);
        av(HR_RDATA, 1'b0, 32'h0);
        chk(q[7:0], 8'h12);
        av(3'h7, 1'b0, 32'h0);
        chk(q, HR_UNMAPPED);
        cfg(8'h01);
        for (int d = 0; d < 4; d++) begin
            setp(16'h0100);
            wb(1'b1, CMD_STEP_DIR | {6'h00, d[1:0]});
            wb(1'b1, CMD_MEM_WRITE);
            wb(1'b0, 8'h5A + d[7:0]);
            chk(ptr, st[d]);
            chk(mem_wdata, 8'h5A + d[7:0]);
            chk(mem_we, 1'b1);
        end
        setp(16'h0200);
        wb(1'b1, CMD_STEP_DIR | {6'h00, DIR_RIGHT});
        wb(1'b1, CMD_MEM_READ);
        av(HR_DATA, 1'b0, 32'h0);
        chk(ptr, 16'h0201);
        wb(1'b1, CMD_PTR_READ);
        av(HR_DATA, 1'b0, 32'h0);
        ls[7:0] = q[7:0];
        av(HR_DATA, 1'b0, 32'h0);
        ls[15:8] = q[7:0];
        setp(16'hF000);
        wb(1'b1, CMD_MEM_WRITE);
        wb(1'b0, 8'h00);
        setp(ls);
        chk(ptr, 16'h0201);
        for (int i = 2; i >= 0; i--) begin
            wb(1'b1, CMD_DEPTH);
            wb(1'b0, i[7:0]);
            chk(depth, i[1:0]);
            @(negedge clk); // Pixel count follows the depth one edge later.
            chk(pix_count, pc[i]);
        end
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            overlay <= i[1];
            setp(i[0] ? 16'h2100 : 16'h0100);
            @(negedge clk); // Visibility follows the pointer one edge later.
            chk(cur_vis, i[1] == i[0]);
            chk(cur_l3, i[1]);
        end
        chk(dummy, 1'b1);
        @(posedge clk);
        text_on <= 1'b1;
        repeat (2) @(negedge clk);
        chk(dummy, 1'b0);
        line(1'b1);
        for (int i = 0; i < 4; i++) begin
            line(1'b1);
            chk(len, 6);
            chk(act, 4);
            chk(lo, 0);
        end
        cfg(8'h02);
        line(1'b0);
        for (int i = 0; i < 2; i++) begin
            line(1'b0);
            chk(len, 12);
            chk(act, 8);
            chk(lo, 6);
        end
        tally_and_finish();
    end
endmodule
